// *** uelf_defines.vh ***
`ifndef UELF_DEFINES_VH
`define UELF_DEFINES_VH
`define UELF_TRIG0_HI     6'h08
`define UELF_TRIG0_LO     6'h00
`define UELF_TRIG1_HI     6'h10
`define UELF_TRIG1_LO     6'h08
`define UELF_TRIG2_HI     6'h18
`define UELF_TRIG2_LO     6'h10
`define UELF_TRIG3_HI     6'h1c
`define UELF_TRIG3_LO     6'h18
`define UELF_FRAME_EXTRA  4'h7
`define UELF_TICKS_PER_BIT 9'h010
`define UELF_IR_PW_RESET  4'h3
`define UELF_WAKE_CODE    4'h1
`define UELF_XSEL_XON1    2'h0
`define UELF_XSEL_XON2    2'h1
`define UELF_XSEL_XOFF1   2'h2
`define UELF_XSEL_XOFF2   2'h3
`endif

// *** uelf_ir_codec.v ***
`timescale 1ns/1ps
`include "uelf_defines.vh"
module uelf_ir_codec (
	input  wire       mclk_in,
	input  wire       rst_in,
	input  wire       ir_mode_in,
	input  wire       ir_half_in,
	input  wire       ir_rx_inv_in,
	input  wire [3:0] ir_pw_in,
	input  wire       txd_in,
	input  wire [3:0] tx_phase_in,
	input  wire       tx_active_in,
	input  wire       rx_pin_in,
	output reg        tx_pin_out,
	output reg        rxd_out
);
	wire rx_pulse;
	assign rx_pulse = ir_rx_inv_in ? ~rx_pin_in : rx_pin_in;

	always @(posedge mclk_in) begin
		if (rst_in) begin
			tx_pin_out <= 1'b1;
			rxd_out    <= 1'b1;
		end else if (ir_mode_in) begin
			// zero bits pulse high for the first ir_pw phases; ones and idle stay low
			tx_pin_out <= ~txd_in & (tx_phase_in < ir_pw_in);
			// echo suppression: hold the receiver at mark while our own LED fires
			if (ir_half_in && tx_active_in)
				rxd_out <= 1'b1;
			else
				rxd_out <= ~rx_pulse;
		end else begin
			tx_pin_out <= txd_in;
			rxd_out    <= rx_pin_in;
		end
	end
endmodule

// *** uelf_core.v ***
`timescale 1ns/1ps
`include "uelf_defines.vh"
module uelf_core #(
	parameter LVL_W = 6
) (
	input  wire             mclk_in,
	input  wire             rst_in,
	input  wire             xchar_we_in,
	input  wire [1:0]       xchar_sel_in,
	input  wire [7:0]       xchar_wdata_in,
	input  wire             sw_rx_fc_en_in,
	input  wire             sw_tx_fc_en_in,
	input  wire             dbl_mode_in,
	input  wire             special_det_en_in,
	input  wire             xoff_int_en_in,
	input  wire             sleep_en_in,
	input  wire [1:0]       word_len_in,
	input  wire             rx_char_valid_in,
	input  wire [7:0]       rx_char_in,
	input  wire [LVL_W-1:0] rx_fifo_level_in,
	input  wire [1:0]       rx_trig_sel_in,
	input  wire             bclk16_in,
	input  wire             tx_fc_ack_in,
	input  wire             tx_load_in,
	input  wire             tx_line_idle_in,
	input  wire             rts_in,
	input  wire             auto_dir_en_in,
	input  wire             dir_invert_in,
	input  wire             infrared_enable_pin_in,
	input  wire             ir_mode_we_in,
	input  wire             ir_mode_wdata_in,
	input  wire             ir_half_in,
	input  wire             ir_rx_inv_in,
	input  wire [3:0]       ir_pw_in,
	input  wire             txd_in,
	input  wire [3:0]       tx_phase_in,
	input  wire             rx_pin_in,
	input  wire             int_pending_in,
	input  wire [3:0]       msr_delta_in,
	input  wire [3:0]       modem_in,
	input  wire             thr_write_in,
	input  wire             isr_read_in,
	output reg              rxf_wr_out,
	output reg  [7:0]       rxf_data_out,
	output reg              tx_halt_out,
	output reg              tx_fc_valid_out,
	output reg  [7:0]       tx_fc_data_out,
	output reg              flag_bit4_out,
	output reg              rts_pin_out,
	output reg              ir_mode_out,
	output wire             tx_pin_out,
	output wire             rxd_out,
	output reg              sleep_out,
	output reg              wake_int_out,
	output reg  [3:0]       wake_code_out
);
	// ****************************************
	// helpers
	// ****************************************
	function [7:0] wl_mask;
		input [1:0] wl;
		begin
			wl_mask = 8'hff >> (2'h3 - wl);
		end
	endfunction

	function eqm;
		input [7:0] a;
		input [7:0] b;
		input [1:0] wl;
		begin
			eqm = ((a ^ b) & wl_mask(wl)) == 8'h00;
		end
	endfunction

	function [LVL_W-1:0] trig_hi;
		input [1:0] s;
		begin
			case (s)
				2'h0: trig_hi = `UELF_TRIG0_HI;
				2'h1: trig_hi = `UELF_TRIG1_HI;
				2'h2: trig_hi = `UELF_TRIG2_HI;
				default: trig_hi = `UELF_TRIG3_HI;
			endcase
		end
	endfunction

	function [LVL_W-1:0] trig_lo;
		input [1:0] s;
		begin
			case (s)
				2'h0: trig_lo = `UELF_TRIG0_LO;
				2'h1: trig_lo = `UELF_TRIG1_LO;
				2'h2: trig_lo = `UELF_TRIG2_LO;
				default: trig_lo = `UELF_TRIG3_LO;
			endcase
		end
	endfunction

	// ****************************************
	// flow control characters
	// ****************************************
	reg [7:0] xon1_q;
	reg [7:0] xon2_q;
	reg [7:0] xoff1_q;
	reg [7:0] xoff2_q;

	always @(posedge mclk_in) begin
		if (rst_in) begin
			xon1_q  <= 8'h00;
			xon2_q  <= 8'h00;
			xoff1_q <= 8'h00;
			xoff2_q <= 8'h00;
		end else if (xchar_we_in) begin
			case (xchar_sel_in)
				`UELF_XSEL_XON1:  xon1_q  <= xchar_wdata_in;
				`UELF_XSEL_XON2:  xon2_q  <= xchar_wdata_in;
				`UELF_XSEL_XOFF1: xoff1_q <= xchar_wdata_in;
				default:          xoff2_q <= xchar_wdata_in;
			endcase
		end
	end

	// ****************************************
	// receive match
	// ****************************************
	reg        pend_q;
	reg [7:0]  pend_char_q;
	reg        stash_q;
	reg [7:0]  stash_char_q;

	wire [1:0] wl = word_len_in;
	wire c_xon1  = eqm(rx_char_in, xon1_q, wl);
	wire c_xon2  = eqm(rx_char_in, xon2_q, wl);
	wire c_xoff1 = eqm(rx_char_in, xoff1_q, wl);
	wire c_xoff2 = eqm(rx_char_in, xoff2_q, wl);
	wire p_xon1  = eqm(pend_char_q, xon1_q, wl);
	wire p_xoff1 = eqm(pend_char_q, xoff1_q, wl);
	wire rxv     = rx_char_valid_in & sw_rx_fc_en_in;

	// single mode matches the first value; double needs first then second
	wire dbl_xon  = rxv & dbl_mode_in & pend_q & p_xon1 & c_xon2;
	wire dbl_xoff = rxv & dbl_mode_in & pend_q & p_xoff1 & c_xoff2;
	wire sgl_xon  = rxv & ~dbl_mode_in & c_xon1;
	wire sgl_xoff = rxv & ~dbl_mode_in & c_xoff1;
	wire xon_hit  = (sgl_xon | dbl_xon) & tx_halt_out;
	wire xoff_hit = sgl_xoff | dbl_xoff;
	wire consumed = xon_hit | xoff_hit;
	wire starts_pair = rxv & dbl_mode_in & ~consumed & (c_xon1 | c_xoff1);
	wire special  = rx_char_valid_in & special_det_en_in & ~consumed & c_xoff2;

	always @(posedge mclk_in) begin
		if (rst_in) begin
			pend_q       <= 1'b0;
			pend_char_q  <= 8'h00;
			stash_q      <= 1'b0;
			stash_char_q <= 8'h00;
			rxf_wr_out   <= 1'b0;
			rxf_data_out <= 8'h00;
		end else begin
			rxf_wr_out <= 1'b0;
			stash_q    <= 1'b0;
			if (stash_q) begin
				rxf_wr_out   <= 1'b1;
				rxf_data_out <= stash_char_q;
			end
			if (rx_char_valid_in) begin
				pend_q      <= starts_pair;
				pend_char_q <= rx_char_in;
				if (consumed) begin
					rxf_wr_out <= 1'b0;
				end else if (pend_q) begin
					// broken pair: the held first character goes in now
					rxf_wr_out   <= 1'b1;
					rxf_data_out <= pend_char_q;
					stash_q      <= ~starts_pair;
					stash_char_q <= rx_char_in;
				end else if (!starts_pair) begin
					rxf_wr_out   <= 1'b1;
					rxf_data_out <= rx_char_in;
				end
			end else if (!sw_rx_fc_en_in && pend_q) begin
				pend_q       <= 1'b0;
				rxf_wr_out   <= 1'b1;
				rxf_data_out <= pend_char_q;
			end
		end
	end

	// halt only gates the start of the next character; the shifter finishes
	always @(posedge mclk_in) begin
		if (rst_in) begin
			tx_halt_out   <= 1'b0;
			flag_bit4_out <= 1'b0;
		end else begin
			if (xoff_hit)
				tx_halt_out <= 1'b1;
			else if (xon_hit || !sw_rx_fc_en_in)
				tx_halt_out <= 1'b0;
			if ((xoff_hit && xoff_int_en_in) || special)
				flag_bit4_out <= 1'b1;
			else if (xon_hit)
				flag_bit4_out <= 1'b0;
		end
	end

	// ****************************************
	// transmit Xoff / Xon
	// ****************************************
	localparam S_IDLE = 2'h0;
	localparam S_DLY  = 2'h1;
	localparam S_C1   = 2'h2;
	localparam S_C2   = 2'h3;

	reg [1:0] st_q;
	reg       sent_off_q;
	reg       send_off_q;
	reg [8:0] dly_q;

	wire [8:0] two_chars = {`UELF_FRAME_EXTRA + {2'h0, wl}, 5'h00}; // 32 ticks per bit pair

	always @(posedge mclk_in) begin
		if (rst_in) begin
			st_q            <= S_IDLE;
			sent_off_q      <= 1'b0;
			send_off_q      <= 1'b0;
			dly_q           <= 9'h000;
			tx_fc_valid_out <= 1'b0;
			tx_fc_data_out  <= 8'h00;
		end else begin
			case (st_q)
				S_IDLE: begin
					if (!sw_tx_fc_en_in) begin
						sent_off_q <= 1'b0;
					end else if (!sent_off_q &&
							rx_fifo_level_in >= trig_hi(rx_trig_sel_in)) begin
						st_q  <= S_DLY;
						dly_q <= two_chars;
					end else if (sent_off_q &&
							rx_fifo_level_in <= trig_lo(rx_trig_sel_in)) begin
						st_q            <= S_C1;
						send_off_q      <= 1'b0;
						tx_fc_valid_out <= 1'b1;
						tx_fc_data_out  <= xon1_q;
					end
				end
				S_DLY: begin
					if (bclk16_in)
						dly_q <= dly_q - 9'h001;
					if (bclk16_in && dly_q == 9'h001) begin
						st_q            <= S_C1;
						send_off_q      <= 1'b1;
						tx_fc_valid_out <= 1'b1;
						tx_fc_data_out  <= xoff1_q;
					end
				end
				S_C1: begin
					if (tx_fc_ack_in) begin
						if (dbl_mode_in) begin
							st_q           <= S_C2;
							tx_fc_data_out <= send_off_q ? xoff2_q : xon2_q;
						end else begin
							st_q            <= S_IDLE;
							tx_fc_valid_out <= 1'b0;
							sent_off_q      <= send_off_q;
						end
					end
				end
				S_C2: begin
					if (tx_fc_ack_in) begin
						st_q            <= S_IDLE;
						tx_fc_valid_out <= 1'b0;
						sent_off_q      <= send_off_q;
					end
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end

	// ****************************************
	// half-duplex direction
	// ****************************************
	reg dir_tx_q;

	always @(posedge mclk_in) begin
		if (rst_in) begin
			dir_tx_q    <= 1'b0;
			rts_pin_out <= 1'b1;
		end else begin
			if (tx_load_in)
				dir_tx_q <= 1'b1;
			else if (tx_line_idle_in)
				dir_tx_q <= 1'b0;
			if (auto_dir_en_in)
				rts_pin_out <= (tx_load_in | dir_tx_q) ^ dir_invert_in;
			else
				rts_pin_out <= rts_in;
		end
	end

	// ****************************************
	// infrared
	// ****************************************
	reg rst_seen_q;

	always @(posedge mclk_in) begin
		rst_seen_q <= rst_in;
		if (rst_in)
			ir_mode_out <= 1'b0;
		else if (rst_seen_q)
			ir_mode_out <= infrared_enable_pin_in;
		else if (ir_mode_we_in)
			ir_mode_out <= ir_mode_wdata_in;
	end

	uelf_ir_codec u_ir (
		.mclk_in      (mclk_in),
		.rst_in       (rst_in),
		.ir_mode_in   (ir_mode_out),
		.ir_half_in   (ir_half_in),
		.ir_rx_inv_in (ir_rx_inv_in),
		.ir_pw_in     (ir_pw_in),
		.txd_in       (txd_in),
		.tx_phase_in  (tx_phase_in),
		.tx_active_in (dir_tx_q),
		.rx_pin_in    (rx_pin_in),
		.tx_pin_out   (tx_pin_out),
		.rxd_out      (rxd_out)
	);

	// ****************************************
	// sleep and wake
	// ****************************************
	reg       rx_prev_q;
	reg [3:0] modem_prev_q;

	wire wake_ev = (rx_prev_q & ~rx_pin_in) | thr_write_in |
		(modem_prev_q != modem_in);
	// deltas stay set until the host reads modem status, which blocks re-entry
	wire can_sleep = ~int_pending_in & ~wake_int_out & sleep_en_in &
		(msr_delta_in == 4'h0) & rx_pin_in & ~wake_ev;

	always @(posedge mclk_in) begin
		if (rst_in) begin
			rx_prev_q     <= 1'b1;
			modem_prev_q  <= 4'h0;
			sleep_out     <= 1'b0;
			wake_int_out  <= 1'b0;
			wake_code_out <= 4'h0;
		end else begin
			rx_prev_q    <= rx_pin_in;
			modem_prev_q <= modem_in;
			if (sleep_out && (wake_ev || !sleep_en_in))
				sleep_out <= 1'b0;
			else if (can_sleep)
				sleep_out <= 1'b1;
			if (sleep_out && wake_ev) begin
				wake_int_out  <= 1'b1;
				wake_code_out <= `UELF_WAKE_CODE;
			end else if (isr_read_in) begin
				wake_int_out  <= 1'b0;
				wake_code_out <= 4'h0;
			end
		end
	end
endmodule

// *** uelf_checker.sv ***
`timescale 1ns/1ps
// ********
// port checker for uelf_core
// ********
module uelf_checker (
	input wire       mclk_in,
	input wire       rst_in,
	input wire       xchar_we_in,
	input wire [1:0] xchar_sel_in,
	input wire [7:0] xchar_wdata_in,
	input wire       sw_rx_fc_en_in,
	input wire       dbl_mode_in,
	input wire       special_det_en_in,
	input wire       xoff_int_en_in,
	input wire       sleep_en_in,
	input wire [1:0] word_len_in,
	input wire       rx_char_valid_in,
	input wire [7:0] rx_char_in,
	input wire       tx_load_in,
	input wire       tx_line_idle_in,
	input wire       auto_dir_en_in,
	input wire       dir_invert_in,
	input wire       int_pending_in,
	input wire [3:0] msr_delta_in,
	input wire       rx_pin_in,
	input wire       thr_write_in,
	input wire       isr_read_in,
	input wire       rxf_wr_out,
	input wire       tx_halt_out,
	input wire       flag_bit4_out,
	input wire       rts_pin_out,
	input wire       sleep_out,
	input wire       wake_int_out,
	input wire [3:0] wake_code_out
);
	logic [7:0] xc_q [4];
	wire  [7:0] msk = 8'hff >> (2'h3 - word_len_in);
	// mirror of the flow characters so that matches can be judged at the ports
	always @(posedge mclk_in) begin
		if (rst_in) xc_q <= '{default: 8'h00};
		else if (xchar_we_in) xc_q[xchar_sel_in] <= xchar_wdata_in;
	end
	wire h_on  = ((rx_char_in ^ xc_q[0]) & msk) == 8'h00;
	wire h_off = ((rx_char_in ^ xc_q[2]) & msk) == 8'h00;
	wire h_sp  = ((rx_char_in ^ xc_q[3]) & msk) == 8'h00;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	sequence s_xoff_rx;
		rx_char_valid_in && sw_rx_fc_en_in && !dbl_mode_in && !special_det_en_in && h_off && !h_on;
	endsequence
	sequence s_woken;
		!sleep_out && wake_int_out && wake_code_out == 4'h1;
	endsequence
	a_xoff_halt: assert property (s_xoff_rx |=> tx_halt_out && !rxf_wr_out)
		else $error("xoff char did not halt or was stored");
	a_xoff_flag: assert property (s_xoff_rx and xoff_int_en_in |=> flag_bit4_out)
		else $error("xoff flag not set");
	a_special_kept: assert property (
		rx_char_valid_in && special_det_en_in && !sw_rx_fc_en_in && h_sp |=> rxf_wr_out && flag_bit4_out)
		else $error("special char not stored or flagged");
	a_dir_load: assert property (auto_dir_en_in && tx_load_in |=> rts_pin_out == !$past(dir_invert_in))
		else $error("direction not transmit on load");
	a_dir_idle: assert property (
		(auto_dir_en_in && tx_line_idle_in && !tx_load_in) [*2] |=> rts_pin_out == $past(dir_invert_in))
		else $error("direction not receive after stop bit");
	a_sleep_cond: assert property (
		$rose(sleep_out) |-> $past(sleep_en_in) && !$past(int_pending_in) &&
			$past(msr_delta_in) == 4'h0 && $past(rx_pin_in))
		else $error("sleep entered without its conditions");
	a_wake_thr: assert property (sleep_out && thr_write_in |=> s_woken)
		else $error("transmit write did not wake");
	a_wake_clear: assert property (wake_int_out && isr_read_in && !sleep_out |=> !wake_int_out)
		else $error("wake interrupt not cleared by source read");
endmodule
bind uelf_core uelf_checker chk (.*);

// *** uelf_remote.sv ***
`timescale 1ns/1ps
// ********
// remote end: sends characters, takes flow characters
// ********
module uelf_remote (
	input  wire       mclk_in,
	input  wire       rst_in,
	input  wire       slow_in,
	input  wire       fc_valid_in,
	input  wire [7:0] fc_data_in,
	output reg        fc_ack_out,
	output reg        char_valid_out,
	output reg  [7:0] char_out,
	output reg  [7:0] last_fc_out
);
	reg [4:0] wait_q;
	initial begin
		fc_ack_out = 1'b0;
		char_valid_out = 1'b0;
		char_out = 8'h00;
		last_fc_out = 8'h00;
	end
	// a slow peer lets the request stand twenty cycles before taking it
	always @(posedge mclk_in) begin
		fc_ack_out <= 1'b0;
		if (rst_in || !fc_valid_in || fc_ack_out) wait_q <= 5'h00;
		else if (wait_q == (slow_in ? 5'h13 : 5'h00)) begin
			fc_ack_out <= 1'b1;
			last_fc_out <= fc_data_in;
		end else wait_q <= wait_q + 5'h01;
	end
	// the data line shows the inverse once the character is gone, so nothing stale matches
	task send_char(input [7:0] c);
		@(posedge mclk_in);
		char_valid_out <= 1'b1;
		char_out <= c;
		@(posedge mclk_in);
		char_valid_out <= 1'b0;
		char_out <= ~c;
		repeat (3) @(posedge mclk_in);
		#1;
	endtask
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
	logic mclk_in = 1'b0, rst_in = 1'b1, xchar_we_in = 1'b0, sw_rx_fc_en_in = 1'b1;
	logic sw_tx_fc_en_in = 1'b0, dbl_mode_in = 1'b0, special_det_en_in = 1'b0, xoff_int_en_in = 1'b1;
	logic sleep_en_in = 1'b0, bclk16_in = 1'b0, tx_load_in = 1'b0, tx_line_idle_in = 1'b1;
	logic rts_in = 1'b1, auto_dir_en_in = 1'b0, dir_invert_in = 1'b0, infrared_enable_pin_in = 1'b1;
	logic ir_mode_we_in = 1'b0, ir_mode_wdata_in = 1'b0, ir_half_in = 1'b0, ir_rx_inv_in = 1'b0;
	logic txd_in = 1'b1, rx_pin_in = 1'b1, thr_write_in = 1'b0, isr_read_in = 1'b0, slow = 1'b0;
	logic [1:0] xchar_sel_in = 2'h0, word_len_in = 2'h3, rx_trig_sel_in = 2'h0;
	logic [7:0] xchar_wdata_in = 8'h00;
	logic [5:0] rx_fifo_level_in = 6'h00;
	logic [3:0] ir_pw_in = 4'h3, tx_phase_in = 4'h0, msr_delta_in = 4'h0, modem_in = 4'h0;
	wire rx_char_valid_in, tx_fc_ack_in, int_pending_in, rxf_wr_out, tx_halt_out, tx_fc_valid_out;
	wire flag_bit4_out, rts_pin_out, ir_mode_out, tx_pin_out, rxd_out, sleep_out, wake_int_out;
	wire [7:0] rx_char_in, fc_seen, rxf_data_out, tx_fc_data_out;
	wire [3:0] wake_code_out;
	logic [7:0] exp_q [$];
	logic [5:0] hi_t [4] = '{6'h08, 6'h10, 6'h18, 6'h1c};
	logic [5:0] lo_t [4] = '{6'h00, 6'h08, 6'h10, 6'h18};
	int num_errors = 0, n_tests = 0, tk, hc;
	// the wake interrupt is what the host sees as pending
	assign int_pending_in = wake_int_out;
	uelf_core dut (.*);
	uelf_remote rp (.mclk_in(mclk_in), .rst_in(rst_in), .slow_in(slow),
		.fc_valid_in(tx_fc_valid_out), .fc_data_in(tx_fc_data_out), .fc_ack_out(tx_fc_ack_in),
		.char_valid_out(rx_char_valid_in), .char_out(rx_char_in), .last_fc_out(fc_seen));
	// ********
	// clocks, checking, closing
	// ********
	initial forever #5 mclk_in = ~mclk_in;
	always @(posedge mclk_in) begin
		bclk16_in <= ~bclk16_in;
		tx_phase_in <= tx_phase_in + 4'h1;
	end
	task check(input [15:0] seen, input [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	always @(posedge mclk_in) begin
		if (rxf_wr_out === 1'b1) begin
			if (exp_q.size() == 0) check(16'h0000, 16'h0001);
			else check(rxf_data_out, exp_q.pop_front());
		end
	end
	task complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// about three thousand cycles of tests; this leaves a wide margin
	initial begin
		#200000;
		num_errors++;
		complete_run();
	end
	task cyc(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask
	task wx(input [1:0] s, input [7:0] v);
		@(posedge mclk_in);
		xchar_we_in <= 1'b1;
		xchar_sel_in <= s;
		xchar_wdata_in <= v;
		@(posedge mclk_in);
		xchar_we_in <= 1'b0;
	endtask
	task rxc(input [7:0] c, input bit keep);
		if (keep) exp_q.push_back(c);
		rp.send_char(c);
	endtask
	task wfc();
		tk = 0;
		for (int w = 0; w < 4000 && tx_fc_valid_out !== 1'b1; w++) begin
			@(posedge mclk_in);
			tk += bclk16_in;
		end
		for (int w = 0; w < 100 && tx_fc_valid_out === 1'b1; w++) @(posedge mclk_in);
		cyc(1);
	endtask
	task wsleep();
		for (int w = 0; w < 50 && sleep_out !== 1'b1; w++) @(posedge mclk_in);
		cyc(1);
		check(sleep_out, 1'b1);
	endtask
	// ********
	// main sequence
	// ********
	initial begin
		void'($urandom(32'he9107646));
		repeat (6) @(posedge mclk_in);
		rst_in <= 1'b0;
		cyc(2);
		check(ir_mode_out, 1'b1);
		ir_mode_we_in <= 1'b1;
		rts_in <= 1'b0;
		cyc(1);
		ir_mode_we_in <= 1'b0;
		cyc(2);
		check(ir_mode_out, 1'b0);
		check(rts_pin_out, 1'b0);
		rxc(8'h00, 0);
		check({tx_halt_out, flag_bit4_out}, 2'h3);
		wx(2'h0, 8'h11);
		wx(2'h1, 8'h91);
		wx(2'h2, 8'h13);
		wx(2'h3, 8'h93);
		rxc(8'h11, 0);
		check({tx_halt_out, flag_bit4_out}, 2'h0);
		rxc(8'h55, 1);
		rxc(8'h13, 0);
		check(tx_halt_out, 1'b1);
		word_len_in <= 2'h0;
		rxc(8'hf1, 0);
		check(tx_halt_out, 1'b0);
		word_len_in <= 2'h3;
		dbl_mode_in <= 1'b1;
		rxc(8'h13, 0);
		rxc(8'h93, 0);
		check(tx_halt_out, 1'b1);
		rxc(8'h13, 1);
		rxc(8'h41, 1);
		rxc(8'h11, 0);
		rxc(8'h91, 0);
		check(tx_halt_out, 1'b0);
		dbl_mode_in <= 1'b0;
		sw_rx_fc_en_in <= 1'b0;
		special_det_en_in <= 1'b1;
		rxc(8'h93, 1);
		check(flag_bit4_out, 1'b1);
		special_det_en_in <= 1'b0;
		repeat (6) rxc(8'($urandom), 1);
		sw_tx_fc_en_in <= 1'b1;
		for (int t = 0; t < 4; t++) begin
			@(posedge mclk_in);
			rx_trig_sel_in <= 2'(t);
			slow <= t[0];
			dbl_mode_in <= t[1];
			rx_fifo_level_in <= hi_t[t];
			wfc();
			check(tk >= 317 && tk <= 323, 1'b1);
			check(fc_seen, t[1] ? 8'h93 : 8'h13);
			rx_fifo_level_in <= lo_t[t] + 6'h01;
			cyc(40);
			check(tx_fc_valid_out, 1'b0);
			rx_fifo_level_in <= lo_t[t];
			wfc();
			check(fc_seen, t[1] ? 8'h91 : 8'h11);
		end
		sw_tx_fc_en_in <= 1'b0;
		dbl_mode_in <= 1'b0;
		sleep_en_in <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			wsleep();
			thr_write_in <= (k == 0);
			rx_pin_in <= (k != 1);
			modem_in <= modem_in ^ {3'h0, k == 2};
			msr_delta_in <= {3'h0, k == 2};
			cyc(1);
			thr_write_in <= 1'b0;
			rx_pin_in <= 1'b1;
			cyc(1);
			check({sleep_out, wake_int_out, wake_code_out}, 6'h11);
			isr_read_in <= 1'b1;
			cyc(1);
			isr_read_in <= 1'b0;
			cyc(2);
			check(wake_int_out, 1'b0);
		end
		cyc(10);
		check(sleep_out, 1'b0);
		msr_delta_in <= 4'h0;
		wsleep();
		sleep_en_in <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			dir_invert_in <= i[0];
			auto_dir_en_in <= 1'b1;
			tx_line_idle_in <= 1'b0;
			tx_load_in <= 1'b1;
			cyc(1);
			tx_load_in <= 1'b0;
			cyc(3);
			check(rts_pin_out, !i[0]);
			tx_line_idle_in <= 1'b1;
			cyc(4);
			check(rts_pin_out, i[0]);
		end
		check(sleep_out, 1'b0);
		ir_mode_we_in <= 1'b1;
		ir_mode_wdata_in <= 1'b1;
		ir_pw_in <= 4'h1 + 4'($urandom % 14);
		tx_load_in <= 1'b1;
		tx_line_idle_in <= 1'b0;
		cyc(1);
		ir_mode_we_in <= 1'b0;
		tx_load_in <= 1'b0;
		rx_pin_in <= 1'b0;
		// step at least one edge so the first sample already sees infrared mode
		do @(posedge mclk_in); while (tx_phase_in !== 4'hf);
		txd_in <= 1'b0;
		hc = 0;
		for (int i = 0; i < 36; i++) begin
			@(posedge mclk_in);
			hc += tx_pin_out;
			if (i == 15) txd_in <= 1'b1;
		end
		cyc(1);
		check(16'(hc), 16'(ir_pw_in));
		check({tx_pin_out, rxd_out}, 2'h1);
		for (int m = 0; m < 3; m++) begin
			ir_rx_inv_in <= (m == 1);
			ir_half_in <= (m == 2);
			tx_line_idle_in <= (m != 2);
			tx_load_in <= (m == 2);
			rx_pin_in <= (m == 1);
			cyc(3);
			check(rxd_out, 1'b1);
			rx_pin_in <= (m != 1);
			cyc(3);
			check(rxd_out, m == 2);
		end
		check(16'(exp_q.size()), 16'h0000);
		complete_run();
	end
endmodule
